// ### shared/vdram_map.vh
// Timing counts and encodings for the video dram controller
`ifndef VDRAM_MAP_VH
`define VDRAM_MAP_VH
`define CLK_MHZ 40
`define T_STEP_NS 100
// Sized to the step counter; equals T_STEP_NS rounded up at CLK_MHZ
`define STEP_CYC 8'h04
`define T_RAS_MAX_US 100
`define RAS_MAX_CYC ((`T_RAS_MAX_US*`CLK_MHZ)-1)
`define T_REF_MS 8
`define REF_ROWS 512
`define REF_PERIOD_CYC ((`T_REF_MS*1000*`CLK_MHZ)/`REF_ROWS)
`define SC_HALF_CYC 8'h04
`define CMD_READ 3'h0
`define CMD_WRITE 3'h1
`define CMD_RD_XFER 3'h2
`define CMD_WR_XFER 3'h3
`define CMD_PWR_XFER 3'h4
`define CMD_SHIFT 3'h5
`endif

// ### design/vdram_host.v
// Host controller driving the dual-port video dram pins
`timescale 1ns/1ps
`include "vdram_map.vh"

//
// Contract
// - Mask presented at every row strobe fall (the refresh row fall leaves the pins released)
// - Serial clock steady during transfers
// - Row strobe active at most 100 us
// - Refresh all 512 rows per 8 ms
// - Read transfer: column high, write-enable high
// - Write transfer: column, write-enable, serial-enable low
// - Pseudo-write: column high, serial-enable high
module vdram_host #(
  parameter REF_PERIOD = `REF_PERIOD_CYC,
  parameter RAS_MAX = `RAS_MAX_CYC
) (
  input wire SYS_CLK_I,
  input wire ARST_N_I,
  input wire CMD_VALID_I,
  input wire [2:0] CMD_I,
  input wire [8:0] ROW_I,
  input wire [8:0] COL_I,
  input wire [3:0] WDATA_I,
  input wire [3:0] MASK_I,
  input wire MASK_EN_I,
  input wire [3:0] SDATA_I,
  output reg CMD_READY_O,
  output reg [3:0] RDATA_O,
  output reg RDATA_VALID_O,
  output reg [3:0] SDATA_O,
  output reg SDATA_VALID_O,
  output reg SERIAL_OUT_MODE_O,
  output reg ROW_STROBE_N_O,
  output reg COL_STROBE_N_O,
  output reg TRANSFER_OR_OUTPUT_ENABLE_N_O,
  output reg MASK_SELECT_OR_WRITE_ENABLE_N_O,
  output reg [8:0] MULTIPLEXED_ADDRESS_PINS_O,
  output reg [3:0] PARALLEL_DATA_MASK_PINS_O,
  output reg PARALLEL_DATA_MASK_PINS_OE_N_O,
  input wire [3:0] PARALLEL_DATA_MASK_PINS_I,
  output reg SERIAL_SHIFT_CLOCK_O,
  output reg SERIAL_PORT_ENABLE_N_O,
  output reg [3:0] SERIAL_DATA_PINS_O,
  output reg SERIAL_DATA_PINS_OE_N_O,
  input wire [3:0] SERIAL_DATA_PINS_I
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and pin sampling

reg [1:0] rst_sync_q;
wire rst_n = rst_sync_q[1];
always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    rst_sync_q <= 2'h0;
  end else begin
    rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
end

// Three stages; second and third agree before use
reg [3:0] pd_s1_q, pd_s2_q, pd_s3_q, pd_q;
reg [3:0] sd_s1_q, sd_s2_q, sd_s3_q, sd_q;
always @(posedge SYS_CLK_I or negedge rst_n) begin
  if (!rst_n) begin
    pd_s1_q <= 4'h0;
    pd_s2_q <= 4'h0;
    pd_s3_q <= 4'h0;
    pd_q <= 4'h0;
    sd_s1_q <= 4'h0;
    sd_s2_q <= 4'h0;
    sd_s3_q <= 4'h0;
    sd_q <= 4'h0;
  end else begin
    pd_s1_q <= PARALLEL_DATA_MASK_PINS_I;
    pd_s2_q <= pd_s1_q;
    pd_s3_q <= pd_s2_q;
    if (pd_s2_q == pd_s3_q) begin
      pd_q <= pd_s3_q;
    end
    sd_s1_q <= SERIAL_DATA_PINS_I;
    sd_s2_q <= sd_s1_q;
    sd_s3_q <= sd_s2_q;
    if (sd_s2_q == sd_s3_q) begin
      sd_q <= sd_s3_q;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Step timer and refresh demand

reg [7:0] step_q;
wire step_done = (step_q == 8'h0);
reg [31:0] ref_cnt_q;
reg ref_pend_q;
reg [31:0] ras_cnt_q;
wire ref_tick = (ref_cnt_q == 32'h0);

localparam S_IDLE = 8'h01;
localparam S_ROW = 8'h02;
localparam S_COL = 8'h04;
localparam S_DATA = 8'h08;
localparam S_END = 8'h10;
localparam S_CBR = 8'h20;
localparam S_SHIFT = 8'h40;
localparam S_PRE = 8'h80;

reg [7:0] st_q;
reg [2:0] cmd_q;
reg [8:0] col_q;
reg [3:0] wdata_q;
reg [7:0] sc_cnt_q;

always @(posedge SYS_CLK_I or negedge rst_n) begin
  if (!rst_n) begin
    ref_cnt_q <= 32'h0;
    ref_pend_q <= 1'b0;
  end else begin
    ref_cnt_q <= ref_tick ? REF_PERIOD - 1 : ref_cnt_q - 32'h1;
    // Set wins over the clear
    if (ref_tick) begin
      ref_pend_q <= 1'b1;
    end else if (st_q == S_CBR && !ROW_STROBE_N_O && step_done) begin
      ref_pend_q <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Main sequencer

always @(posedge SYS_CLK_I or negedge rst_n) begin
  if (!rst_n) begin
    st_q <= S_IDLE;
    step_q <= 8'h0;
    cmd_q <= 3'h0;
    col_q <= 9'h0;
    wdata_q <= 4'h0;
    sc_cnt_q <= 8'h0;
    ras_cnt_q <= 32'h0;
    CMD_READY_O <= 1'b0;
    RDATA_O <= 4'h0;
    RDATA_VALID_O <= 1'b0;
    SDATA_O <= 4'h0;
    SDATA_VALID_O <= 1'b0;
    SERIAL_OUT_MODE_O <= 1'b0;
    ROW_STROBE_N_O <= 1'b1;
    COL_STROBE_N_O <= 1'b1;
    TRANSFER_OR_OUTPUT_ENABLE_N_O <= 1'b1;
    MASK_SELECT_OR_WRITE_ENABLE_N_O <= 1'b1;
    MULTIPLEXED_ADDRESS_PINS_O <= 9'h0;
    PARALLEL_DATA_MASK_PINS_O <= 4'h0;
    PARALLEL_DATA_MASK_PINS_OE_N_O <= 1'b1;
    SERIAL_SHIFT_CLOCK_O <= 1'b0;
    SERIAL_PORT_ENABLE_N_O <= 1'b1;
    SERIAL_DATA_PINS_O <= 4'h0;
    SERIAL_DATA_PINS_OE_N_O <= 1'b1;
  end else begin
    RDATA_VALID_O <= 1'b0;
    SDATA_VALID_O <= 1'b0;
    CMD_READY_O <= 1'b0;
    ras_cnt_q <= ROW_STROBE_N_O ? 32'h0 : ras_cnt_q + 32'h1;
    if (!step_done) begin
      step_q <= step_q - 8'h1;
    end
    case (st_q)
      S_IDLE: begin
        if (ref_pend_q) begin
          // Column before row gives counter refresh
          COL_STROBE_N_O <= 1'b0;
          step_q <= `STEP_CYC;
          st_q <= S_CBR;
        end else if (CMD_VALID_I && CMD_READY_O) begin
          cmd_q <= CMD_I;
          col_q <= COL_I;
          wdata_q <= WDATA_I;
          if (CMD_I == `CMD_SHIFT) begin
            // Pins carry serial data only in input mode
            SERIAL_PORT_ENABLE_N_O <= 1'b0;
            SERIAL_DATA_PINS_O <= SDATA_I;
            sc_cnt_q <= `SC_HALF_CYC;
            st_q <= S_SHIFT;
          end else begin
            // Controls set up before row fall, held at least through it
            MULTIPLEXED_ADDRESS_PINS_O <= ROW_I;
            TRANSFER_OR_OUTPUT_ENABLE_N_O <= (CMD_I == `CMD_READ ||
              CMD_I == `CMD_WRITE);
            MASK_SELECT_OR_WRITE_ENABLE_N_O <= !((CMD_I == `CMD_WRITE &&
              MASK_EN_I) || CMD_I == `CMD_WR_XFER ||
              CMD_I == `CMD_PWR_XFER);
            SERIAL_PORT_ENABLE_N_O <= (CMD_I != `CMD_WR_XFER);
            COL_STROBE_N_O <= (CMD_I != `CMD_WR_XFER);
            // Mask always driven; ones write all lanes when unused
            PARALLEL_DATA_MASK_PINS_O <= (CMD_I == `CMD_WRITE &&
              MASK_EN_I) ? MASK_I : 4'hf;
            PARALLEL_DATA_MASK_PINS_OE_N_O <= 1'b0;
            step_q <= `STEP_CYC;
            st_q <= S_ROW;
          end
        end else begin
          // Drop ready ahead of a refresh so no command is lost
          CMD_READY_O <= !ref_tick;
        end
      end
      S_ROW: begin
        if (step_done) begin
          ROW_STROBE_N_O <= 1'b0;
          step_q <= `STEP_CYC;
          st_q <= S_COL;
        end
      end
      S_COL: begin
        if (step_done) begin
          MULTIPLEXED_ADDRESS_PINS_O <= col_q;
          // Column strobe cycled so the tap is latched in every transfer
          COL_STROBE_N_O <= 1'b1;
          PARALLEL_DATA_MASK_PINS_OE_N_O <= (cmd_q != `CMD_WRITE);
          PARALLEL_DATA_MASK_PINS_O <= wdata_q;
          if (cmd_q == `CMD_WRITE) begin
            // Data latched at later of strobe and write enable
            MASK_SELECT_OR_WRITE_ENABLE_N_O <= 1'b0;
          end
          if (cmd_q == `CMD_READ) begin
            TRANSFER_OR_OUTPUT_ENABLE_N_O <= 1'b0;
          end
          step_q <= `STEP_CYC;
          st_q <= S_DATA;
        end
      end
      S_DATA: begin
        if (step_done) begin
          COL_STROBE_N_O <= 1'b0;
          step_q <= (`STEP_CYC << 1);
          st_q <= S_END;
        end
      end
      S_END: begin
        // Row strobe never held past the limit
        if (step_done || ras_cnt_q >= RAS_MAX) begin
          if (cmd_q == `CMD_READ) begin
            RDATA_O <= pd_q;
            RDATA_VALID_O <= 1'b1;
          end
          // Transfer-enable rise completes the read transfer
          TRANSFER_OR_OUTPUT_ENABLE_N_O <= 1'b1;
          if (cmd_q == `CMD_RD_XFER) begin
            SERIAL_OUT_MODE_O <= 1'b1;
          end else if (cmd_q == `CMD_WR_XFER || cmd_q == `CMD_PWR_XFER) begin
            SERIAL_OUT_MODE_O <= 1'b0;
          end
          st_q <= S_PRE;
          step_q <= `STEP_CYC;
        end
      end
      S_CBR: begin
        if (step_done) begin
          if (ROW_STROBE_N_O) begin
            ROW_STROBE_N_O <= 1'b0;
            step_q <= (`STEP_CYC << 1);
          end else begin
            st_q <= S_PRE;
            step_q <= `STEP_CYC;
          end
        end
      end
      S_PRE: begin
        ROW_STROBE_N_O <= 1'b1;
        COL_STROBE_N_O <= 1'b1;
        MASK_SELECT_OR_WRITE_ENABLE_N_O <= 1'b1;
        SERIAL_PORT_ENABLE_N_O <= 1'b1;
        PARALLEL_DATA_MASK_PINS_OE_N_O <= 1'b1;
        if (step_done && ROW_STROBE_N_O) begin
          st_q <= S_IDLE;
        end
      end
      S_SHIFT: begin
        // Serial clock only toggles here, never in transfers
        SERIAL_DATA_PINS_OE_N_O <= SERIAL_OUT_MODE_O;
        if (sc_cnt_q != 8'h0) begin
          sc_cnt_q <= sc_cnt_q - 8'h1;
        end else if (!SERIAL_SHIFT_CLOCK_O) begin
          SERIAL_SHIFT_CLOCK_O <= 1'b1;
          sc_cnt_q <= `SC_HALF_CYC;
        end else begin
          SERIAL_SHIFT_CLOCK_O <= 1'b0;
          SDATA_O <= sd_q;
          SDATA_VALID_O <= SERIAL_OUT_MODE_O;
          SERIAL_PORT_ENABLE_N_O <= 1'b1;
          SERIAL_DATA_PINS_OE_N_O <= 1'b1;
          st_q <= S_IDLE;
        end
      end
      default: begin
        st_q <= S_IDLE;
      end
    endcase
  end
end

endmodule

// ### test/vdram_host_checker.sv
// Pin protocol checker for the video dram host
`timescale 1ns/1ps
module vdram_host_checker #(
  parameter RAS_MAX = 3999
) (
  input wire SYS_CLK_I,
  input wire ARST_N_I,
  input wire ROW_STROBE_N_O,
  input wire COL_STROBE_N_O,
  input wire TRANSFER_OR_OUTPUT_ENABLE_N_O,
  input wire MASK_SELECT_OR_WRITE_ENABLE_N_O,
  input wire PARALLEL_DATA_MASK_PINS_OE_N_O,
  input wire SERIAL_SHIFT_CLOCK_O,
  input wire SERIAL_PORT_ENABLE_N_O
);
  wire ras = ROW_STROBE_N_O;
  wire cas = COL_STROBE_N_O;
  wire toe = TRANSFER_OR_OUTPUT_ENABLE_N_O;
  wire we = MASK_SELECT_OR_WRITE_ENABLE_N_O;
  wire doe = PARALLEL_DATA_MASK_PINS_OE_N_O;
  wire sc = SERIAL_SHIFT_CLOCK_O;
  wire se = SERIAL_PORT_ENABLE_N_O;
  logic [15:0] low_q;
  logic xf_q;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  ////////////////////////////////////////////////////////////////////////////
  // Row low time and transfer cycle tracking
  always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      low_q <= 16'h0;
      xf_q <= 1'b0;
    end else begin
      low_q <= ras ? 16'h0 : low_q + 16'h1;
      xf_q <= ras ? 1'b0 : ($fell(ras) ? !toe : xf_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_ras_max; low_q <= RAS_MAX + 1; endproperty
  a_ras_max: assert property (p_ras_max) else $error("row low too long");
  property p_mask; $fell(ras) && toe && cas && !we |-> !doe; endproperty
  a_mask: assert property (p_mask) else $error("mask not driven");
  property p_wdata; $fell(cas) && !ras && !we && !xf_q |-> !doe; endproperty
  a_wdata: assert property (p_wdata) else $error("write data missing");
  property p_clash;
    !ras && !cas && !toe && !xf_q && !$fell(ras) |-> doe;
  endproperty
  a_clash: assert property (p_clash) else $error("data pin clash");
  property p_sc_still; xf_q && !ras && !toe |-> $stable(sc); endproperty
  a_sc_still: assert property (p_sc_still) else $error("sc moved");
  property p_sc_pulse; $rose(sc) |-> sc [*5] ##1 !sc; endproperty
  a_sc_pulse: assert property (p_sc_pulse) else $error("sc pulse width");
  property p_rd_xfer; $fell(ras) && !toe && we |-> cas; endproperty
  a_rd_xfer: assert property (p_rd_xfer) else $error("read xfer code");
  property p_wr_xfer; $fell(ras) && !toe && !we |-> cas == se; endproperty
  a_wr_xfer: assert property (p_wr_xfer) else $error("write xfer code");
  property p_cbr; $fell(cas) && ras |-> ##[1:12] !ras; endproperty
  a_cbr: assert property (p_cbr) else $error("refresh row missing");
endmodule

// ### test/vdram_dev_model.sv
// Behavioural dual port video dram for the host bench
`timescale 1ns/1ps
module vdram_dev_model (
  input wire ras,
  input wire cas,
  input wire toe,
  input wire we,
  input wire sc,
  input wire se,
  input wire [8:0] a,
  input wire [3:0] dq_i,
  input wire [3:0] sio_i,
  output wire [3:0] dq_o,
  output wire [3:0] sio_o
);
  logic [3:0] mem [0:262143];
  logic [3:0] serial_access_register [0:511];
  logic [8:0] row, col, ptr, rcnt;
  logic [3:0] msk, rq, sq;
  logic xf, rdx, sout;
  initial begin
    {rq, sq, sout, rcnt, xf, rdx} = '0;
  end
  task wr;
    for (int i = 0; i < 4; i++) if (msk[i]) mem[{row, col}][i] = dq_i[i];
  endtask
  always @(negedge ras) begin
    row = a;
    xf = !toe;
    rdx = xf && cas && we;
    msk = we ? 4'hf : dq_i;
    if (xf) sout = rdx;
    if (!cas && toe) rcnt = rcnt + 9'h1;
  end
  always @(negedge cas) if (!ras) begin
    col = a;
    if (xf) ptr = a;
    else if (!we) wr;
    else rq = mem[{row, a}];
  end
  always @(negedge we) if (!ras && !cas && !xf) wr;
  always @(posedge toe) if (rdx) begin
    for (int i = 0; i < 512; i++) serial_access_register[i] = mem[{row, i[8:0]}];
    rdx = 0;
  end
  // Serial clock moves the pointer even with the port disabled
  always @(posedge sc) begin
    if (sout) sq = serial_access_register[ptr];
    else if (!se) serial_access_register[ptr] = sio_i;
    ptr = ptr + 9'h1;
  end
  // Released pins show the inverse so stale data never matches
  assign dq_o = (!cas && !toe) ? rq : ~rq;
  assign sio_o = (sout && !se) ? sq : ~sq;
endmodule

// ### test/vdram_host_test.sv
// Self-checking bench for the video dram host controller
`timescale 1ns/1ps
module vdram_host_test;
  logic clk = 0, rst_n = 0, vld = 0, men = 0;
  logic [2:0] cmd = 0;
  logic [8:0] row = 0, col = 0;
  logic [3:0] wd = 0, mk = 0, sdi = 0, rq, sq;
  wire rdy, rdv, sdv, som, ras, cas, toe, we, doe, sc, se, soe;
  wire [3:0] rd, sd, dqh, dqd, sioh, siod;
  wire [8:0] adr;
  wire [3:0] dq = !doe ? dqh : dqd;
  wire [3:0] sio = !soe ? sioh : siod;
  int failures = 0, compares = 0;
  vdram_host #(.REF_PERIOD(200)) i_vdram_host (.SYS_CLK_I(clk),
    .ARST_N_I(rst_n), .CMD_VALID_I(vld), .CMD_I(cmd), .ROW_I(row),
    .COL_I(col), .WDATA_I(wd), .MASK_I(mk), .MASK_EN_I(men),
    .SDATA_I(sdi), .CMD_READY_O(rdy), .RDATA_O(rd), .RDATA_VALID_O(rdv),
    .SDATA_O(sd), .SDATA_VALID_O(sdv), .SERIAL_OUT_MODE_O(som),
    .ROW_STROBE_N_O(ras), .COL_STROBE_N_O(cas),
    .TRANSFER_OR_OUTPUT_ENABLE_N_O(toe),
    .MASK_SELECT_OR_WRITE_ENABLE_N_O(we),
    .MULTIPLEXED_ADDRESS_PINS_O(adr), .PARALLEL_DATA_MASK_PINS_O(dqh),
    .PARALLEL_DATA_MASK_PINS_OE_N_O(doe), .PARALLEL_DATA_MASK_PINS_I(dq),
    .SERIAL_SHIFT_CLOCK_O(sc), .SERIAL_PORT_ENABLE_N_O(se),
    .SERIAL_DATA_PINS_O(sioh), .SERIAL_DATA_PINS_OE_N_O(soe),
    .SERIAL_DATA_PINS_I(sio));
  vdram_dev_model i_vdram_dev_model (.ras(ras), .cas(cas), .toe(toe),
    .we(we), .sc(sc), .se(se), .a(adr), .dq_i(dq), .sio_i(sio),
    .dq_o(dqd), .sio_o(siod));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (rdv === 1'b1) rq <= rd;
  always @(posedge clk) if (sdv === 1'b1) sq <= sd;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [3:0] g, input [3:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is sampled at the falling edge, before the taking edge
  task go(input [2:0] c, input [8:0] r, input [8:0] k, input [3:0] w,
    input [3:0] m, input e);
    int n;
    n = 0;
    @(posedge clk);
    {cmd, row, col, wd, mk, men, vld} <= {c, r, k, w, m, e, 1'b1};
    do @(negedge clk); while (rdy !== 1'b1 && ++n < 4000);
    @(posedge clk);
    vld <= 1'b0;
    repeat (2) @(posedge clk);
    do @(negedge clk); while (rdy !== 1'b1 && ++n < 4000);
    if (n >= 4000) begin
      failures++;
      test_done;
    end
  endtask
  task test_done;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_rw;
    go(3'h1, 9'h3, 9'h5, 4'ha, 4'h0, 1'b0);
    go(3'h0, 9'h3, 9'h5, 4'h0, 4'h0, 1'b0);
    chk(rq, 4'ha);
    $display("test rw done");
  endtask
  task t_mask;
    go(3'h1, 9'h3, 9'h5, 4'h5, 4'h3, 1'b1);
    go(3'h0, 9'h3, 9'h5, 4'h0, 4'h0, 1'b0);
    chk(rq, 4'h9);
    $display("test mask done");
  endtask
  task t_xfer;
    go(3'h1, 9'h3, 9'h1ff, 4'hc, 4'h0, 1'b0);
    go(3'h1, 9'h3, 9'h0, 4'hd, 4'h0, 1'b0);
    go(3'h2, 9'h3, 9'h1ff, 4'h0, 4'h0, 1'b0);
    chk({3'h0, som}, 4'h1);
    go(3'h5, 9'h0, 9'h0, 4'h0, 4'h0, 1'b0);
    chk(sq, 4'hc);
    go(3'h5, 9'h0, 9'h0, 4'h0, 4'h0, 1'b0);
    chk(sq, 4'hd);
    $display("test xfer done");
  endtask
  task t_mode;
    go(3'h4, 9'h4, 9'h7, 4'h0, 4'h0, 1'b0);
    chk({3'h0, som}, 4'h0);
    go(3'h2, 9'h3, 9'h0, 4'h0, 4'h0, 1'b0);
    go(3'h3, 9'h4, 9'h7, 4'h0, 4'h0, 1'b0);
    chk({3'h0, som}, 4'h0);
    chk({3'h0, i_vdram_dev_model.rcnt != 9'h0}, 4'h1);
    $display("test mode done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_rw;
    t_mask;
    t_xfer;
    t_mode;
    test_done;
  end
  initial begin
    #2000000;
    failures++;
    test_done;
  end
endmodule
bind vdram_host vdram_host_checker #(.RAS_MAX(RAS_MAX)) i_chk (.*);
